// >>> abrw_host_sequencer.sv
/*
  Host-side sequencer that reads and writes an asynchronous 8K x 8 byte RAM through
  its pins: location lines, two chip selects, output enable, write strobe, byte bus.
  Assumes the RAM sits on the board with the byte bus resolved outside from the enable;
  byte bus input is taken as synchronous to mclk. One command at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module abrw_host_sequencer
   import abrw_pkg::*;
#(
   parameter int AW             = abrw_pkg::ADDR_W,
   parameter int DW             = abrw_pkg::DATA_W,
   parameter int PERIOD_NS      = abrw_pkg::CLK_PERIOD_NS,
   parameter int LOC_ACCESS     = abrw_pkg::LOC_ACCESS_NS,
   parameter int SEL_ACCESS     = abrw_pkg::SEL_ACCESS_NS,
   parameter int OE_ACCESS      = abrw_pkg::OE_ACCESS_NS,
   parameter int OE_FLOAT       = abrw_pkg::OE_FLOAT_NS,
   parameter int SEL_FLOAT      = abrw_pkg::SEL_FLOAT_NS,
   parameter int STROBE_WIDTH   = abrw_pkg::STROBE_WIDTH_NS,
   parameter int LOC_TO_END     = abrw_pkg::LOC_TO_END_NS,
   parameter int DATA_SETUP     = abrw_pkg::DATA_SETUP_NS,
   parameter int DATA_HOLD      = abrw_pkg::DATA_HOLD_NS,
   parameter int LOC_HOLD       = abrw_pkg::LOC_HOLD_NS,
   parameter int WRITE_RECOVERY = abrw_pkg::WRITE_RECOVERY_NS
) (
   input  wire logic          mclk,
   input  wire logic          reset_n,
   // User command side
   input  wire logic          cmd_valid,
   input  wire logic          cmd_write,
   input  wire logic [AW-1:0] cmd_addr,
   input  wire logic [DW-1:0] cmd_wdata,
   output logic               cmd_ready,
   output logic               rsp_valid,
   output logic [DW-1:0]      rsp_rdata,
   // RAM pin side
   output logic [AW-1:0]      location_lines,
   output logic               chip_select_low_active_n,
   output logic               chip_select_high_active,
   output logic               output_enable_n,
   output logic               write_strobe_n,
   input  wire logic [DW-1:0] byte_bus_i,
   output logic [DW-1:0]      byte_bus_o,
   output logic               byte_bus_oe
);

   // ----------------------------------------------------------------------
   // Derived cycle counts
   // ----------------------------------------------------------------------
   // Read waits for the latest of location, select and output enable access
   localparam int RD_CYC = abrw_max2(abrw_max2(abrw_min_cycles(LOC_ACCESS, PERIOD_NS),
                                               abrw_min_cycles(SEL_ACCESS, PERIOD_NS)),
                                     abrw_min_cycles(OE_ACCESS, PERIOD_NS));
   // Bus turnaround after a read before the host drives
   localparam int FL_CYC = abrw_max2(abrw_min_cycles(OE_FLOAT, PERIOD_NS),
                                     abrw_min_cycles(SEL_FLOAT, PERIOD_NS));
   // Strobe low time covers width, location-to-end and data setup
   localparam int WP_CYC = abrw_max2(abrw_max2(abrw_min_cycles(STROBE_WIDTH, PERIOD_NS),
                                               abrw_min_cycles(LOC_TO_END, PERIOD_NS)),
                                     abrw_min_cycles(DATA_SETUP, PERIOD_NS));
   // Hold location and data after the write ends
   localparam int WH_CYC = abrw_max2(abrw_min_cycles(LOC_HOLD, PERIOD_NS),
                                     abrw_min_cycles(DATA_HOLD, PERIOD_NS));
   localparam int RC_CYC = abrw_min_cycles(WRITE_RECOVERY, PERIOD_NS);

   localparam logic [TIMER_W-1:0] RD_LOAD = TIMER_W'(RD_CYC - 1);
   localparam logic [TIMER_W-1:0] FL_LOAD = TIMER_W'(FL_CYC - 1);
   localparam logic [TIMER_W-1:0] WP_LOAD = TIMER_W'(WP_CYC - 1);
   localparam logic [TIMER_W-1:0] WH_LOAD = TIMER_W'(WH_CYC - 1);
   localparam logic [TIMER_W-1:0] RC_LOAD = TIMER_W'(RC_CYC - 1);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   // Parameterised timing for either speed grade
   if (AW != ADDR_W || (1 << AW) != DEPTH) begin : g_bad_aw
      $error("location width must address exactly the byte array");
   end
   if (DW != DATA_W) begin : g_bad_dw
      $error("byte bus width must be eight");
   end
   if (PERIOD_NS < 1) begin : g_bad_period
      $error("clock period must be positive");
   end
   if (abrw_max2(abrw_max2(RD_CYC, WP_CYC), abrw_max2(FL_CYC, WH_CYC)) > (1 << TIMER_W)
       || RC_CYC > (1 << TIMER_W)) begin : g_bad_timer
      $error("a timing count does not fit the wait timer");
   end

   // ----------------------------------------------------------------------
   // State and timer
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ABRW_IDLE,
      ABRW_RD_ACCESS,
      ABRW_RD_FLOAT,
      ABRW_WR_PULSE,
      ABRW_WR_HOLD,
      ABRW_RECOVER
   } abrw_state_t;

   abrw_state_t          state_reg;
   logic                 timer_load;
   logic [TIMER_W-1:0]   timer_value;
   logic                 timer_done;
   logic                 take_cmd;

   assign take_cmd = cmd_valid && cmd_ready && (state_reg == ABRW_IDLE);

   abrw_wait_timer #(
      .W          (TIMER_W)
   ) u_timer (
      .mclk       (mclk),
      .reset_n    (reset_n),
      .load       (timer_load),
      .load_value (timer_value),
      .done       (timer_done)
   );

   // Timer load on entry to every state but idle
   always_comb begin
      timer_load  = 1'b0;
      timer_value = '0;
      unique case (state_reg)
         ABRW_IDLE: begin
            timer_load  = take_cmd;
            timer_value = cmd_write ? WP_LOAD : RD_LOAD;
         end
         ABRW_RD_ACCESS: begin
            timer_load  = timer_done;
            timer_value = FL_LOAD;
         end
         ABRW_WR_PULSE: begin
            timer_load  = timer_done;
            timer_value = WH_LOAD;
         end
         ABRW_WR_HOLD: begin
            timer_load  = timer_done;
            timer_value = RC_LOAD;
         end
         ABRW_RD_FLOAT,
         ABRW_RECOVER: begin
            timer_load  = 1'b0;
            timer_value = '0;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------------
   // State progression, one access at a time
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ABRW_IDLE;
      end else begin
         unique case (state_reg)
            ABRW_IDLE: begin
               if (take_cmd) begin
                  state_reg <= cmd_write ? ABRW_WR_PULSE : ABRW_RD_ACCESS;
               end
            end
            ABRW_RD_ACCESS: if (timer_done) state_reg <= ABRW_RD_FLOAT;
            ABRW_RD_FLOAT:  if (timer_done) state_reg <= ABRW_IDLE;
            ABRW_WR_PULSE:  if (timer_done) state_reg <= ABRW_WR_HOLD;
            ABRW_WR_HOLD:   if (timer_done) state_reg <= ABRW_RECOVER;
            ABRW_RECOVER:   if (timer_done) state_reg <= ABRW_IDLE;
         endcase
      end
   end

   // Ready only while idle and not just leaving idle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_ready <= 1'b0;
      end else if (take_cmd) begin
         cmd_ready <= 1'b0;
      end else begin
         cmd_ready <= (state_reg == ABRW_IDLE) ||
                      (timer_done && (state_reg == ABRW_RD_FLOAT ||
                                      state_reg == ABRW_RECOVER));
      end
   end

   // Location lines: set with the cycle start, held through write and hold
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         location_lines <= '0;
      end else if (take_cmd) begin
         location_lines <= cmd_addr;
      end
   end

   // Both selects active for the access, released at its end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         chip_select_low_active_n <= 1'b1;
         chip_select_high_active  <= 1'b0;
      end else if (take_cmd) begin
         chip_select_low_active_n <= 1'b0;
         chip_select_high_active  <= 1'b1;
      end else if (timer_done && (state_reg == ABRW_RD_ACCESS ||
                                  state_reg == ABRW_WR_PULSE)) begin
         chip_select_low_active_n <= 1'b1; // Float or write hold follows
         chip_select_high_active  <= 1'b0;
      end
   end

   // Output enable only for reads, never during writes
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         output_enable_n <= 1'b1;
      end else if (take_cmd) begin
         output_enable_n <= cmd_write;
      end else if (timer_done && state_reg == ABRW_RD_ACCESS) begin
         output_enable_n <= 1'b1;
      end
   end

   // Strobe low with the selects; it rises on the same edge as the selects to end the write
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         write_strobe_n <= 1'b1;
      end else if (take_cmd) begin
         write_strobe_n <= !cmd_write; // Write when low read when high
      end else if (timer_done && state_reg == ABRW_WR_PULSE) begin
         write_strobe_n <= 1'b1;
      end
   end

   // Write data driven through the pulse and the hold time
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         byte_bus_o  <= '0;
         byte_bus_oe <= 1'b0;
      end else if (take_cmd && cmd_write) begin
         byte_bus_o  <= cmd_wdata;
         byte_bus_oe <= 1'b1;
      end else if (timer_done && state_reg == ABRW_WR_HOLD) begin
         byte_bus_oe <= 1'b0;
      end
   end

   // Sample read data once the slowest access has elapsed
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= timer_done && (state_reg == ABRW_RD_ACCESS);
         if (timer_done && state_reg == ABRW_RD_ACCESS) begin
            rsp_rdata <= byte_bus_i;
         end
      end
   end

endmodule

`default_nettype wire

// >>> abrw_pkg.sv
/*
  Shared constants for the host-side sequencer of an asynchronous 8K x 8 byte RAM port.
  Assumes one clock, mclk, at 20 MHz. All times are in ns for the faster speed grade.
*/
// How it works
// - Host holds the location through the write and 10 ns after it ends.
// - Host keeps strobe or selects inactive for recovery before the next cycle.
// - Host drives write data 50 ns before write end and 5 ns after.
// - Host keeps output enable inactive during writes to avoid bus contention.
// - Host holds the write strobe low at least 80 ns.
// - Host presents the location no later than the strobe fall, zero setup.
// - Host keeps the location valid 80 ns before the write strobe rises.
`default_nettype none

package abrw_pkg;

   // ----------------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int DEPTH  = 8192;

   // ----------------------------------------------------------------------
   // Clock and timing (ns)
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS      = 50;
   localparam int LOC_ACCESS_NS      = 100; // location_access_time
   localparam int SEL_ACCESS_NS      = 100; // select to output valid
   localparam int OE_ACCESS_NS       = 50;  // output_drive_access_time
   localparam int OE_FLOAT_NS        = 40;  // output enable high to float
   localparam int SEL_FLOAT_NS       = 50;  // select inactive to float
   localparam int STROBE_WIDTH_NS    = 80;  // write strobe low width
   localparam int LOC_TO_END_NS      = 80;  // location valid to write end
   localparam int DATA_SETUP_NS      = 50;  // write_data_setup
   localparam int DATA_HOLD_NS       = 5;   // write_data_hold
   localparam int LOC_HOLD_NS        = 10;  // location hold after write end
   localparam int WRITE_RECOVERY_NS  = 10;  // recovery before next cycle
   localparam int TIMER_W            = 8;

   // Least time to whole cycles, never below one
   function automatic int abrw_min_cycles(input int ns, input int period);
      int c;
      c = (ns + period - 1) / period;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int abrw_max2(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

endpackage

`default_nettype wire

// >>> abrw_wait_timer.sv
/*
  Down-counting wait timer for the byte RAM sequencer.
  Assumes the caller loads the count minus one on the cycle a wait begins.
*/
`timescale 1ns/1ps
`default_nettype none

module abrw_wait_timer #(
   parameter int W = 8
) (
   input  wire logic         mclk,
   input  wire logic         reset_n,
   input  wire logic         load,
   input  wire logic [W-1:0] load_value,
   output logic              done
);

   logic [W-1:0] count_reg;

   // Count down to zero and rest there
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= '0;
      end else if (load) begin
         count_reg <= load_value;
      end else if (count_reg != '0) begin
         count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
      end
   end

   // Done once the count is spent; load is fed back from done, so not read here
   assign done = (count_reg == '0);

endmodule

`default_nettype wire

// >>> abrw_properties.sv
/*
  Pin-side checker for the byte RAM host sequencer.
  Assumes it is bound into abrw_host_sequencer, one clock mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module abrw_properties #(
   parameter int AW = 13,
   parameter int DW = 8
) (
   input wire logic          mclk,
   input wire logic          reset_n,
   input wire logic          cmd_valid,
   input wire logic          cmd_write,
   input wire logic [AW-1:0] cmd_addr,
   input wire logic [DW-1:0] cmd_wdata,
   input wire logic          cmd_ready,
   input wire logic          rsp_valid,
   input wire logic [DW-1:0] rsp_rdata,
   input wire logic [AW-1:0] location_lines,
   input wire logic          chip_select_low_active_n,
   input wire logic          chip_select_high_active,
   input wire logic          output_enable_n,
   input wire logic          write_strobe_n,
   input wire logic [DW-1:0] byte_bus_i,
   input wire logic [DW-1:0] byte_bus_o,
   input wire logic          byte_bus_oe
);
   // ---------------------------------
   // Properties
   // ---------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // Read take, two driven cycles, then the answer
   sequence s_take_read;
      cmd_valid && cmd_ready && !cmd_write;
   endsequence
   sequence s_read_drive;
      (!output_enable_n && !chip_select_low_active_n && chip_select_high_active)[*2];
   endsequence
   property p_read_sample;
      s_take_read |=> s_read_drive ##1 (rsp_valid && rsp_rdata == $past(byte_bus_i));
   endproperty
   a_read_sample: assert property (p_read_sample)
      else $error("read byte not taken after access time");
   property p_strobe_width;
      $fell(write_strobe_n) |=> !write_strobe_n;
   endproperty
   a_strobe_width: assert property (p_strobe_width)
      else $error("write strobe pulse too short");
   property p_loc_before_end;
      $fell(write_strobe_n) |-> ##2 ($rose(write_strobe_n) && $stable(location_lines));
   endproperty
   a_loc_before_end: assert property (p_loc_before_end)
      else $error("write end too soon after location");
   property p_loc_hold;
      $fell(write_strobe_n) |=> $stable(location_lines)[*3];
   endproperty
   a_loc_hold: assert property (p_loc_hold)
      else $error("location moved during or just after write");
   property p_loc_setup;
      $fell(write_strobe_n) |-> location_lines == $past(cmd_addr) && byte_bus_oe
         && byte_bus_o == $past(cmd_wdata) && !chip_select_low_active_n;
   endproperty
   a_loc_setup: assert property (p_loc_setup)
      else $error("strobe fell without location and selects");
   property p_data_window;
      $rose(write_strobe_n) |-> byte_bus_oe && $past(byte_bus_oe) && $stable(byte_bus_o);
   endproperty
   a_data_window: assert property (p_data_window)
      else $error("write data not held around write end");
   property p_no_contention;
      (!write_strobe_n || byte_bus_oe) |-> output_enable_n;
   endproperty
   a_no_contention: assert property (p_no_contention)
      else $error("output enable active while host drives");
   property p_recovery;
      $rose(write_strobe_n) |-> (chip_select_low_active_n && !chip_select_high_active)[*3];
   endproperty
   a_recovery: assert property (p_recovery)
      else $error("next access before write recovery");
   property p_turnaround;
      $rose(output_enable_n) |-> !byte_bus_oe ##1 !byte_bus_oe;
   endproperty
   a_turnaround: assert property (p_turnaround)
      else $error("host drove the byte bus before read float time");
endmodule

bind abrw_host_sequencer abrw_properties #(.AW(AW), .DW(DW)) u_props (
   .mclk                     (mclk),
   .reset_n                  (reset_n),
   .cmd_valid                (cmd_valid),
   .cmd_write                (cmd_write),
   .cmd_addr                 (cmd_addr),
   .cmd_wdata                (cmd_wdata),
   .cmd_ready                (cmd_ready),
   .rsp_valid                (rsp_valid),
   .rsp_rdata                (rsp_rdata),
   .location_lines           (location_lines),
   .chip_select_low_active_n (chip_select_low_active_n),
   .chip_select_high_active  (chip_select_high_active),
   .output_enable_n          (output_enable_n),
   .write_strobe_n           (write_strobe_n),
   .byte_bus_i               (byte_bus_i),
   .byte_bus_o               (byte_bus_o),
   .byte_bus_oe              (byte_bus_oe)
);

`default_nettype wire

// >>> abrw_ram_model.sv
/*
  Behavioural 8K x 8 asynchronous byte RAM for the bench.
  Assumes the bench resolves the byte bus from the host enable alone.
*/
`timescale 1ns/1ps
`default_nettype none

module abrw_ram_model #(
   parameter int LOC_ACC = abrw_pkg::LOC_ACCESS_NS,
   parameter int SEL_ACC = abrw_pkg::SEL_ACCESS_NS,
   parameter int OE_ACC  = abrw_pkg::OE_ACCESS_NS,
   parameter int HOLD    = abrw_pkg::DATA_HOLD_NS
) (
   input wire logic [abrw_pkg::ADDR_W-1:0] location_lines,
   input wire logic                        chip_select_low_active_n,
   input wire logic                        chip_select_high_active,
   input wire logic                        output_enable_n,
   input wire logic                        write_strobe_n,
   input wire logic [abrw_pkg::DATA_W-1:0] byte_bus_i,
   output logic [abrw_pkg::DATA_W-1:0]     ram_dq
);
   import abrw_pkg::*;
   logic [7:0] mem [0:DEPTH-1];
   logic [7:0] q;
   logic [7:0] last;
   logic       drv;
   realtime    t_a;
   realtime    t_s;
   realtime    t_o;
   wire sel   = !chip_select_low_active_n && chip_select_high_active;
   wire wr_on = sel && !write_strobe_n;
   wire rd_on = sel && write_strobe_n && !output_enable_n;

   // Times of the last location change, select assertion and enable fall
   always @(location_lines) t_a = $realtime;
   always @(posedge sel) t_s = $realtime;
   always @(negedge output_enable_n) t_o = $realtime;

   // Store at the first edge that ends a write
   always @(negedge wr_on) mem[location_lines] = byte_bus_i;

   // Output stage, one ns grain offset by half a ns
   initial begin
      q    = 8'h00;
      last = 8'h00;
      drv  = 1'b0;
      #0.5;
      forever begin
         drv = rd_on;
         if (rd_on && $realtime + 0.5 >= t_a + LOC_ACC && $realtime + 0.5 >= t_s + SEL_ACC
             && $realtime + 0.5 >= t_o + OE_ACC)
            q = mem[location_lines];
         else if (rd_on && $realtime >= t_a + HOLD)
            q = 8'hXX;
         if (drv)
            last = q;
         #1;
      end
   end

   // Released bus shows the inverse of the last byte
   assign ram_dq = drv ? q : ~last;
endmodule

`default_nettype wire

// >>> testbench.sv
/*
  Self-checking bench for the byte RAM host sequencer.
  Assumes abrw_ram_model on the pins and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import abrw_pkg::*;
   localparam int LIMIT = 3000;
   logic              mclk;
   logic              reset_n;
   logic              cmd_valid;
   logic              cmd_write;
   logic [ADDR_W-1:0] cmd_addr;
   logic [DATA_W-1:0] cmd_wdata;
   logic              cmd_ready;
   logic              rsp_valid;
   logic [DATA_W-1:0] rsp_rdata;
   logic [ADDR_W-1:0] location_lines;
   logic              chip_select_low_active_n;
   logic              chip_select_high_active;
   logic              output_enable_n;
   logic              write_strobe_n;
   logic [DATA_W-1:0] byte_bus_o;
   logic              byte_bus_oe;
   logic [DATA_W-1:0] ram_dq;
   wire logic [DATA_W-1:0] byte_bus_i = byte_bus_oe ? byte_bus_o : ram_dq;
   int                err_total = 0;
   int                checked = 0;
   int                cycles = 0;

   abrw_host_sequencer u_dut (
      .mclk                     (mclk),
      .reset_n                  (reset_n),
      .cmd_valid                (cmd_valid),
      .cmd_write                (cmd_write),
      .cmd_addr                 (cmd_addr),
      .cmd_wdata                (cmd_wdata),
      .cmd_ready                (cmd_ready),
      .rsp_valid                (rsp_valid),
      .rsp_rdata                (rsp_rdata),
      .location_lines           (location_lines),
      .chip_select_low_active_n (chip_select_low_active_n),
      .chip_select_high_active  (chip_select_high_active),
      .output_enable_n          (output_enable_n),
      .write_strobe_n           (write_strobe_n),
      .byte_bus_i               (byte_bus_i),
      .byte_bus_o               (byte_bus_o),
      .byte_bus_oe              (byte_bus_oe)
   );
   abrw_ram_model u_ram (
      .location_lines           (location_lines),
      .chip_select_low_active_n (chip_select_low_active_n),
      .chip_select_high_active  (chip_select_high_active),
      .output_enable_n          (output_enable_n),
      .write_strobe_n           (write_strobe_n),
      .byte_bus_i               (byte_bus_i),
      .ram_dq                   (ram_dq)
   );

   // Clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // ---------------------------------
   // Tasks
   // ---------------------------------
   task automatic fail(input string msg);
      err_total++;
      $display("ERROR at %0t ns: %s", $time, msg);
   endtask

   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Hold a command until it is taken
   task automatic issue(input logic w, input logic [12:0] a, input logic [7:0] d);
      int n;
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_addr  <= a;
      cmd_wdata <= d;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 20);
      if (n >= 20)
         fail("command not taken");
   endtask

   task automatic do_read(input logic [12:0] a, input logic [7:0] e);
      int n;
      issue(1'b0, a, 8'h00);
      cmd_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 10);
      checked++;
      if (n != 3) fail("read answer at wrong cycle");
      checked++;
      if (rsp_rdata !== e) fail("read byte mismatch");
   endtask

   task automatic t_reset_idle;
      checked++;
      if (byte_bus_oe !== 1'b0 || output_enable_n !== 1'b1 ||
          chip_select_low_active_n !== 1'b1 || write_strobe_n !== 1'b1)
         fail("pins active in reset");
   endtask

   // Back-to-back writes at both ends of the space
   task automatic t_fill_back;
      issue(1'b1, 13'h0000, 8'h5A);
      issue(1'b1, 13'h1FFF, 8'hA5);
      issue(1'b1, 13'h1000, 8'h3C);
      do_read(13'h1FFF, 8'hA5);
      do_read(13'h0000, 8'h5A);
      do_read(13'h1000, 8'h3C);
   endtask

   task automatic t_overwrite;
      issue(1'b1, 13'h0AAA, 8'hFF);
      issue(1'b1, 13'h0AAA, 8'h00);
      do_read(13'h0AAA, 8'h00);
      do_read(13'h0AAA, 8'h00);
   endtask

   // Reset in mid-write, then an older byte is intact
   task automatic t_abort;
      issue(1'b1, 13'h0007, 8'h81);
      cmd_valid <= 1'b0;
      @(posedge mclk);
      reset_n <= 1'b0;
      #1;
      checked++;
      if (write_strobe_n !== 1'b1 || byte_bus_oe !== 1'b0) fail("write not cut");
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (2) @(posedge mclk);
      do_read(13'h1FFF, 8'hA5);
   endtask

   // Hang guard
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fail("run did not finish");
         stop_test();
      end
   end

   // Main sequence
   initial begin
      reset_n   = 1'b0;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_addr  = 13'h0000;
      cmd_wdata = 8'h00;
      repeat (20) @(posedge mclk);
      t_reset_idle();
      reset_n <= 1'b1;
      repeat (2) @(posedge mclk);
      t_fill_back();
      t_overwrite();
      t_abort();
      stop_test();
   end
endmodule

`default_nettype wire
